// >>> rtl/dsau_consts.vh
// Purpose: Constants for the data-space address unit
// Assumes: 16-bit data addresses, 10-bit program counter
// Notes:   Definitions only
`ifndef DSAU_CONSTS_VH
`define DSAU_CONSTS_VH
// ****************************************
// Data space map
// ****************************************
`define DSAU_REG_BASE   16'h0000
`define DSAU_IO_BASE    16'h0020
`define DSAU_SRAM_BASE  16'h0060
`define DSAU_SRAM_END   16'h00df
`define DSAU_BITIO_LAST 6'h1f
// ****************************************
// Register file pointers
// ****************************************
`define DSAU_PTRA_LO    5'h1a
`define DSAU_PTRB_LO    5'h1c
`define DSAU_PTRC_LO    5'h1e
// ****************************************
// I/O registers
// ****************************************
`define DSAU_OFS_SPL    6'h3d
`define DSAU_OFS_SPH    6'h3e
`define DSAU_OFS_FLAGS  6'h3f
`define DSAU_RST_SPL    8'h00
`define DSAU_RST_SPH    8'h00
`define DSAU_RST_FLAGS  8'h00
// ****************************************
// Address modes
// ****************************************
`define DSAU_M_DIRECT   3'h0
`define DSAU_M_DISP     3'h1
`define DSAU_M_IND      3'h2
`define DSAU_M_PREDEC   3'h3
`define DSAU_M_POSTINC  3'h4
`define DSAU_M_IO       3'h5
// ****************************************
// Program flow operations
// ****************************************
`define DSAU_P_NEXT     2'h0
`define DSAU_P_PTR      2'h1
`define DSAU_P_REL      2'h2
`define DSAU_P_HOLD     2'h3
// ****************************************
// Timing
// ****************************************
`define DSAU_SRAM_CYC   2'h2
`endif

// >>> rtl/dsau_top.v
// Purpose: Data-space decode, operand address generation and program counter
// Assumes: Inputs synchronous to clock_i; caller holds requests until ready
// Notes:   Register file, I/O bytes at 0x3d..0x3f and SRAM live here
`timescale 1ns/1ps
`include "dsau_consts.vh"

// How it works
// - Low 224 addresses: 96 regs+I/O, 128 SRAM
// - 0x00-0x1f registers, 0x20-0x5f I/O
// - Entries 26..31 form three 16-bit pointers
// - Direct mode uses full 16-bit second word
// - Displacement adds unsigned 6-bit field to b/c
// - Indirect uses pointer unchanged
// - Pre-decrement: decrement, use, keep value
// - Post-increment: use original, then increment
// - I/O direct: 6-bit address plus register
// - Constant fetch: pointer_c word and byte
// - Pointer jump/call loads pc from pointer_c
// - Relative: pc plus offset plus one
// - Register ALU op completes in one cycle
// - SRAM access takes two clock cycles
// - Fetch overlaps execute, one per cycle
// - Core clock from divided oscillator input
// - Bit operations only for I/O 0x00-0x1f
// - Bit ops write back set flags, clearing
// - Program counter 10 bits, 1024 words
module dsau_top #(
  parameter PC_W  = 10,
  parameter CLK_DIV = 1
) (
  input  wire        clock_i,
  input  wire        srst_i,
  input  wire        osc_ce_i,
  input  wire        acc_req_i,
  input  wire [2:0]  acc_mode_i,
  input  wire [1:0]  acc_ptr_i,
  input  wire        acc_we_i,
  input  wire [15:0] acc_direct_i,
  input  wire [5:0]  acc_field_i,
  input  wire [4:0]  acc_reg_i,
  input  wire        bit_req_i,
  input  wire        bit_set_i,
  input  wire [2:0]  bit_num_i,
  input  wire [5:0]  bit_io_i,
  input  wire        alu_req_i,
  input  wire [4:0]  alu_rd_i,
  input  wire [4:0]  alu_rr_i,
  input  wire [2:0]  alu_op_i,
  input  wire        pc_step_i,
  input  wire [1:0]  pc_op_i,
  input  wire [11:0] pc_rel_i,
  input  wire        lpc_req_i,
  input  wire [7:0]  io_rdata_i,
  input  wire [7:0]  w1c_mask_i,
  output wire        acc_ready_o,
  output reg         acc_done_o,
  output reg  [15:0] acc_addr_o,
  output reg  [7:0]  acc_rdata_o,
  output reg         acc_unmapped_o,
  output reg         bit_done_o,
  output reg         bit_value_o,
  output reg         bit_refused_o,
  output reg         io_we_o,
  output reg         io_re_o,
  output reg  [5:0]  io_addr_o,
  output reg  [7:0]  io_wdata_o,
  output reg  [PC_W-1:0] pc_o,
  output reg  [PC_W-1:0] lpc_word_o,
  output reg         lpc_high_o,
  output reg         core_ce_o,
  output reg  [7:0]  core_flags_o,
  output reg  [15:0] stack_ptr_o
);

  // ****************************************
  // Storage
  // ****************************************
  reg  [7:0]  regs [0:31];
  reg  [7:0]  sram [0:127];
  reg  [7:0]  stack_pointer_low;
  reg  [7:0]  stack_pointer_high;
  reg  [7:0]  flags;
  reg  [15:0] div_cnt;
  reg         sram_busy;
  reg  [15:0] sram_addr;
  reg         sram_we;
  reg  [4:0]  sram_reg;
  reg  [15:0] next_addr;
  reg  [15:0] next_ptr;
  reg         ptr_upd;
  reg  [7:0]  alu_res;
  reg  [7:0]  io_rd;
  reg  [7:0]  bit_old;
  wire        ce;
  wire [15:0] ptr_a;
  wire [15:0] ptr_b;
  wire [15:0] ptr_c;
  wire [15:0] ptr_sel;
  wire [4:0]  ptr_lo;
  wire        in_reg;
  wire        in_io;
  wire        in_sram;
  wire [5:0]  io_ofs;
  wire [6:0]  sram_ofs;
  wire [PC_W-1:0] rel_ext;

  // Core clock enable divided from oscillator enable
  assign ce = osc_ce_i & core_ce_o;

  // Pointer pairs from top six register entries
  assign ptr_a = {regs[5'h1b], regs[5'h1a]};
  assign ptr_b = {regs[5'h1d], regs[5'h1c]};
  assign ptr_c = {regs[5'h1f], regs[5'h1e]};
  assign ptr_sel = (acc_ptr_i == 2'h0) ? ptr_a : (acc_ptr_i == 2'h1) ? ptr_b : ptr_c;
  assign ptr_lo  = (acc_ptr_i == 2'h0) ? `DSAU_PTRA_LO :
                   (acc_ptr_i == 2'h1) ? `DSAU_PTRB_LO : `DSAU_PTRC_LO;

  // ****************************************
  // Operand address generation
  // ****************************************
  always @* begin
    next_addr = acc_direct_i;
    next_ptr  = ptr_sel;
    ptr_upd   = 1'b0;
    case (acc_mode_i)
      `DSAU_M_DIRECT: next_addr = acc_direct_i;
      `DSAU_M_DISP: begin
        next_addr = ((acc_ptr_i == 2'h1) ? ptr_b : ptr_c) + {10'h000, acc_field_i};
      end
      `DSAU_M_IND: next_addr = ptr_sel;
      `DSAU_M_PREDEC: begin
        next_addr = ptr_sel - 16'h0001;
        next_ptr  = ptr_sel - 16'h0001;
        ptr_upd   = 1'b1;
      end
      `DSAU_M_POSTINC: begin
        next_addr = ptr_sel;
        next_ptr  = ptr_sel + 16'h0001;
        ptr_upd   = 1'b1;
      end
      `DSAU_M_IO: next_addr = `DSAU_IO_BASE + {10'h000, acc_field_i};
      default: next_addr = acc_direct_i;
    endcase
  end

  // Region decode of the unified data space
  assign in_reg  = (next_addr < `DSAU_IO_BASE);
  assign in_io   = (next_addr >= `DSAU_IO_BASE) && (next_addr < `DSAU_SRAM_BASE);
  assign in_sram = (next_addr >= `DSAU_SRAM_BASE) && (next_addr <= `DSAU_SRAM_END);
  assign io_ofs   = next_addr[5:0] - 6'h20;
  assign sram_ofs = next_addr[6:0] - 7'h60;

  // Local I/O bytes or external I/O read data
  always @* begin
    case (io_ofs)
      `DSAU_OFS_SPL:   io_rd = stack_pointer_low;
      `DSAU_OFS_SPH:   io_rd = stack_pointer_high;
      `DSAU_OFS_FLAGS: io_rd = flags;
      default:         io_rd = io_rdata_i;
    endcase
  end

  // Stall new requests while SRAM second cycle runs
  assign acc_ready_o = ~sram_busy;

  // ALU result for register-register ops
  always @* begin
    case (alu_op_i)
      3'h0: alu_res = regs[alu_rd_i] + regs[alu_rr_i];
      3'h1: alu_res = regs[alu_rd_i] - regs[alu_rr_i];
      3'h2: alu_res = regs[alu_rd_i] & regs[alu_rr_i];
      3'h3: alu_res = regs[alu_rd_i] | regs[alu_rr_i];
      3'h4: alu_res = regs[alu_rd_i] ^ regs[alu_rr_i];
      default: alu_res = regs[alu_rr_i];
    endcase
  end

  // Bit op reads whole register, flags set read as one
  always @* begin
    case (bit_io_i)
      `DSAU_OFS_SPL: bit_old = stack_pointer_low;
      default:       bit_old = io_rdata_i;
    endcase
  end

  assign rel_ext = pc_rel_i[PC_W-1:0];

  // ****************************************
  // Clock divider
  // ****************************************
  always @(posedge clock_i) begin
    if (srst_i) begin
      div_cnt   <= 16'h0000;
      core_ce_o <= 1'b0;
    end else if (osc_ce_i) begin
      if (div_cnt >= CLK_DIV[15:0] - 16'h0001) begin
        div_cnt   <= 16'h0000;
        core_ce_o <= 1'b1;
      end else begin
        div_cnt   <= div_cnt + 16'h0001;
        core_ce_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Access, ALU and I/O sequencing
  // ****************************************
  always @(posedge clock_i) begin : seq
    integer k;
    if (srst_i) begin
      stack_pointer_low            <= `DSAU_RST_SPL;
      stack_pointer_high            <= `DSAU_RST_SPH;
      flags          <= `DSAU_RST_FLAGS;
      sram_busy      <= 1'b0;
      sram_addr      <= 16'h0000;
      sram_we        <= 1'b0;
      sram_reg       <= 5'h00;
      acc_done_o     <= 1'b0;
      acc_addr_o     <= 16'h0000;
      acc_rdata_o    <= 8'h00;
      acc_unmapped_o <= 1'b0;
      bit_done_o     <= 1'b0;
      bit_value_o    <= 1'b0;
      bit_refused_o  <= 1'b0;
      io_we_o        <= 1'b0;
      io_re_o        <= 1'b0;
      io_addr_o      <= 6'h00;
      io_wdata_o     <= 8'h00;
      for (k = 0; k < 32; k = k + 1) begin
        regs[k] <= 8'h00;
      end
    end else if (ce) begin
      acc_done_o     <= 1'b0;
      acc_unmapped_o <= 1'b0;
      bit_done_o     <= 1'b0;
      bit_refused_o  <= 1'b0;
      io_we_o        <= 1'b0;
      io_re_o        <= 1'b0;
      // Single-cycle register ALU op
      if (alu_req_i) begin
        regs[alu_rd_i] <= alu_res;
      end
      if (sram_busy) begin
        // Second SRAM cycle completes the access
        sram_busy  <= 1'b0;
        acc_done_o <= 1'b1;
        if (sram_we) begin
          sram[sram_addr[6:0] - 7'h60] <= regs[sram_reg];
        end else begin
          acc_rdata_o    <= sram[sram_addr[6:0] - 7'h60];
          regs[sram_reg] <= sram[sram_addr[6:0] - 7'h60];
        end
      end else if (acc_req_i) begin
        acc_addr_o <= next_addr;
        if (ptr_upd) begin
          regs[ptr_lo]        <= next_ptr[7:0];
          regs[ptr_lo + 5'h1] <= next_ptr[15:8];
        end
        if (in_sram) begin
          sram_busy <= 1'b1;
          sram_addr <= next_addr;
          sram_we   <= acc_we_i;
          sram_reg  <= acc_reg_i;
        end else if (in_reg) begin
          acc_done_o <= 1'b1;
          if (acc_we_i) begin
            regs[next_addr[4:0]] <= regs[acc_reg_i];
          end else begin
            acc_rdata_o    <= regs[next_addr[4:0]];
            regs[acc_reg_i] <= regs[next_addr[4:0]];
          end
        end else if (in_io) begin
          acc_done_o <= 1'b1;
          io_addr_o  <= io_ofs;
          io_wdata_o <= regs[acc_reg_i];
          if (acc_we_i) begin
            case (io_ofs)
              `DSAU_OFS_SPL:   stack_pointer_low   <= regs[acc_reg_i];
              `DSAU_OFS_SPH:   stack_pointer_high   <= regs[acc_reg_i];
              `DSAU_OFS_FLAGS: flags <= regs[acc_reg_i];
              default:         io_we_o <= 1'b1;
            endcase
          end else begin
            io_re_o         <= 1'b1;
            acc_rdata_o     <= io_rd;
            regs[acc_reg_i] <= io_rd;
          end
        end else begin
          // Outside the 224-byte map: refused, no data effect; pre/post pointer update still done
          acc_done_o     <= 1'b1;
          acc_unmapped_o <= 1'b1;
          acc_rdata_o    <= 8'h00;
        end
      end else if (bit_req_i) begin
        bit_done_o <= 1'b1;
        if (bit_io_i > `DSAU_BITIO_LAST) begin
          bit_refused_o <= 1'b1;
        end else begin
          io_addr_o   <= bit_io_i;
          io_re_o     <= 1'b1;
          bit_value_o <= bit_old[bit_num_i];
          // Whole register rewritten; set flags go back as ones
          io_we_o    <= 1'b1;
          io_wdata_o <= bit_set_i ? (bit_old | (8'h01 << bit_num_i)) :
                        (bit_old & ~(8'h01 << bit_num_i)) | (bit_old & w1c_mask_i);
        end
      end
    end
  end

  // ****************************************
  // Program counter and constant fetch
  // ****************************************
  always @(posedge clock_i) begin
    if (srst_i) begin
      pc_o       <= {PC_W{1'b0}};
      lpc_word_o <= {PC_W{1'b0}};
      lpc_high_o <= 1'b0;
    end else if (ce) begin
      if (pc_step_i) begin
        case (pc_op_i)
          `DSAU_P_NEXT: pc_o <= pc_o + {{(PC_W-1){1'b0}}, 1'b1};
          `DSAU_P_PTR:  pc_o <= ptr_c[PC_W-1:0];
          `DSAU_P_REL:  pc_o <= pc_o + rel_ext + {{(PC_W-1){1'b0}}, 1'b1};
          default:      pc_o <= pc_o;
        endcase
      end
      if (lpc_req_i) begin
        lpc_word_o <= ptr_c[PC_W:1];
        lpc_high_o <= ptr_c[0];
      end
    end
  end

  // Registered views of the core I/O bytes
  always @(posedge clock_i) begin
    if (srst_i) begin
      core_flags_o <= 8'h00;
      stack_ptr_o  <= 16'h0000;
    end else if (osc_ce_i) begin
      core_flags_o <= flags;
      stack_ptr_o  <= {stack_pointer_high, stack_pointer_low};
    end
  end

endmodule // dsau_top

// >>> bench/dsau_properties.sv
// Purpose: Port assertions for dsau_top
// Assumes: One clock, CLK_DIV of 1
// Notes:   Bound below the module
`timescale 1ns/1ps
module dsau_properties #(
  parameter PC_W = 10
) (
  input wire            clock_i,
  input wire            srst_i,
  input wire            osc_ce_i,
  input wire            core_ce_o,
  input wire            acc_req_i,
  input wire            acc_ready_o,
  input wire [2:0]      acc_mode_i,
  input wire [15:0]     acc_direct_i,
  input wire [5:0]      acc_field_i,
  input wire            acc_done_o,
  input wire            acc_unmapped_o,
  input wire [15:0]     acc_addr_o,
  input wire            bit_req_i,
  input wire [5:0]      bit_io_i,
  input wire            bit_done_o,
  input wire            bit_refused_o,
  input wire            io_we_o,
  input wire            pc_step_i,
  input wire [1:0]      pc_op_i,
  input wire [11:0]     pc_rel_i,
  input wire [PC_W-1:0] pc_o
);
  // ******
  // Decoded takes
  // ******
  wire            ce    = osc_ce_i & core_ce_o;
  wire            take  = ce & acc_req_i & acc_ready_o;
  wire            dir   = take & (acc_mode_i == 3'h0);
  wire            sram  = dir & (acc_direct_i >= 16'h0060) & (acc_direct_i <= 16'h00df);
  wire            bop   = ce & bit_req_i & acc_ready_o & ~acc_req_i;
  wire [PC_W-1:0] rel_k = pc_rel_i[PC_W-1:0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ******
  // Assertions
  // ******
  AST_SRAM_BUSY: assert property (
    sram |-> ##1 !acc_ready_o) else $error("sram take kept ready high");
  AST_SRAM_DONE: assert property (
    sram |-> ##1 !acc_done_o ##1 acc_done_o) else $error("sram done not on second cycle");
  AST_REG_DONE: assert property (
    dir && acc_direct_i < 16'h0060 |-> ##1 acc_done_o && !acc_unmapped_o)
    else $error("register or io access not done in one cycle");
  AST_UNMAPPED: assert property (
    dir && acc_direct_i > 16'h00df |-> ##1 acc_done_o && acc_unmapped_o)
    else $error("high address not flagged unmapped");
  AST_DIRECT_ADDR: assert property (
    dir && acc_direct_i <= 16'h00df |-> ##1 acc_addr_o == $past(acc_direct_i))
    else $error("direct address not passed through");
  AST_IO_ADDR: assert property (
    take && acc_mode_i == 3'h5 |-> ##1 acc_addr_o == {10'h000, $past(acc_field_i)} + 16'h0020)
    else $error("io address not offset by 0x20");
  AST_BIT_REFUSE: assert property (
    bop && bit_io_i > 6'h1f |-> ##1 bit_done_o && bit_refused_o && !io_we_o)
    else $error("bit op above 0x1f not refused");
  AST_BIT_ACCEPT: assert property (
    bop && bit_io_i <= 6'h1f |-> ##1 bit_done_o && !bit_refused_o)
    else $error("bit op in low io refused");
  AST_PC_REL: assert property (
    ce && pc_step_i && pc_op_i == 2'h2 |-> ##1 pc_o == $past(pc_o) + $past(rel_k) + 1'b1)
    else $error("relative pc step wrong");
  // Main scenario covers
  COV_SRAM: cover property (sram);
  COV_UNMAP: cover property (dir && acc_direct_i > 16'h00df);
  COV_REFUSE: cover property (bop && bit_io_i > 6'h1f);
endmodule // dsau_properties

bind dsau_top dsau_properties #(.PC_W(PC_W)) i_dsau_properties (
  .clock_i(clock_i), .srst_i(srst_i), .osc_ce_i(osc_ce_i), .core_ce_o(core_ce_o),
  .acc_req_i(acc_req_i), .acc_ready_o(acc_ready_o), .acc_mode_i(acc_mode_i),
  .acc_direct_i(acc_direct_i), .acc_field_i(acc_field_i), .acc_done_o(acc_done_o),
  .acc_unmapped_o(acc_unmapped_o), .acc_addr_o(acc_addr_o), .bit_req_i(bit_req_i),
  .bit_io_i(bit_io_i), .bit_done_o(bit_done_o), .bit_refused_o(bit_refused_o),
  .io_we_o(io_we_o), .pc_step_i(pc_step_i), .pc_op_i(pc_op_i), .pc_rel_i(pc_rel_i),
  .pc_o(pc_o)
);

// >>> bench/dsau_io_model.sv
// Purpose: I/O register space behind dsau_top
// Assumes: Read data comes from the addressed byte
// Notes:   fill presets every location
`timescale 1ns/1ps
module dsau_io_model (
  input  wire       clock_i,
  input  wire       we_i,
  input  wire [5:0] addr_i,
  input  wire [7:0] wdata_i,
  output wire [7:0] rdata_o,
  output wire [7:0] w1c_o
);
  logic [7:0] mem [0:63];
  logic [7:0] last_wr = 8'h00;
  int         wr_cnt  = 0;
  // Read data and write-one-clear bits
  assign rdata_o = mem[addr_i];
  assign w1c_o   = 8'h01;
  // Capture io writes
  always @(posedge clock_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
      last_wr     <= wdata_i;
      wr_cnt      <= wr_cnt + 1;
    end
  end
  // Preset all locations
  task fill(input logic [7:0] v);
    for (int k = 0; k < 64; k++) mem[k] = v;
  endtask
  initial fill(8'h00);
endmodule // dsau_io_model

// >>> bench/tb_dsau_top.sv
// Purpose: Self-checking bench for dsau_top
// Assumes: CLK_DIV of 1, osc enable held high
// Notes:   Random data from a fixed seed
`timescale 1ns/1ps
module tb_dsau_top;
  logic        clock_i = 0, srst_i = 1, osc_ce_i = 1, acc_req_i = 0, acc_we_i = 0;
  logic        bit_req_i = 0, bit_set_i = 0, alu_req_i = 0, pc_step_i = 0, lpc_req_i = 0;
  logic [2:0]  acc_mode_i = 0, bit_num_i = 0, alu_op_i = 0;
  logic [1:0]  acc_ptr_i = 0, pc_op_i = 0;
  logic [15:0] acc_direct_i = 0, z;
  logic [5:0]  acc_field_i = 0, bit_io_i = 0;
  logic [4:0]  acc_reg_i = 0, alu_rd_i = 0, alu_rr_i = 0;
  logic [11:0] pc_rel_i = 0;
  logic [7:0]  a, b;
  logic [9:0]  pc;
  logic [1:0]  flg;
  wire         acc_ready_o, acc_done_o, acc_unmapped_o, bit_done_o, bit_value_o;
  wire         bit_refused_o, io_we_o, io_re_o, lpc_high_o, core_ce_o;
  wire [15:0]  acc_addr_o, stack_ptr_o;
  wire [7:0]   acc_rdata_o, io_wdata_o, core_flags_o, io_rdata_i, w1c_mask_i;
  wire [5:0]   io_addr_o;
  wire [9:0]   pc_o, lpc_word_o;
  int          err_total = 0, comparisons = 0, cyc = 0, lat, n;
  dsau_top #(.PC_W(10), .CLK_DIV(1)) i_dsau_top (
    .clock_i(clock_i), .srst_i(srst_i), .osc_ce_i(osc_ce_i), .acc_req_i(acc_req_i),
    .acc_mode_i(acc_mode_i), .acc_ptr_i(acc_ptr_i), .acc_we_i(acc_we_i),
    .acc_direct_i(acc_direct_i), .acc_field_i(acc_field_i), .acc_reg_i(acc_reg_i),
    .bit_req_i(bit_req_i), .bit_set_i(bit_set_i), .bit_num_i(bit_num_i), .bit_io_i(bit_io_i),
    .alu_req_i(alu_req_i), .alu_rd_i(alu_rd_i), .alu_rr_i(alu_rr_i), .alu_op_i(alu_op_i),
    .pc_step_i(pc_step_i), .pc_op_i(pc_op_i), .pc_rel_i(pc_rel_i), .lpc_req_i(lpc_req_i),
    .io_rdata_i(io_rdata_i), .w1c_mask_i(w1c_mask_i), .acc_ready_o(acc_ready_o),
    .acc_done_o(acc_done_o), .acc_addr_o(acc_addr_o), .acc_rdata_o(acc_rdata_o),
    .acc_unmapped_o(acc_unmapped_o), .bit_done_o(bit_done_o), .bit_value_o(bit_value_o),
    .bit_refused_o(bit_refused_o), .io_we_o(io_we_o), .io_re_o(io_re_o),
    .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o), .pc_o(pc_o), .lpc_word_o(lpc_word_o),
    .lpc_high_o(lpc_high_o), .core_ce_o(core_ce_o), .core_flags_o(core_flags_o),
    .stack_ptr_o(stack_ptr_o));
  dsau_io_model i_dsau_io_model (.clock_i(clock_i), .we_i(io_we_o), .addr_i(io_addr_o),
    .wdata_i(io_wdata_o), .rdata_o(io_rdata_i), .w1c_o(w1c_mask_i));
  // ******
  // Clock, timeout, helpers
  // ******
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      close_out;
    end
  end
  task close_out;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task step;
    @(posedge clock_i);
    #1;
  endtask
  // One data access held until taken, then wait for done
  task acc(input logic [2:0] m, input logic [1:0] p, input logic we, input logic [15:0] d,
           input logic [5:0] f, input logic [4:0] r);
    n = 0;
    {acc_mode_i, acc_ptr_i, acc_we_i, acc_direct_i, acc_field_i, acc_reg_i} = {m, p, we, d, f, r};
    acc_req_i = 1;
    while (acc_ready_o !== 1'b1 && n < 8) begin step; n++; end
    step;
    acc_req_i = 0;
    lat = 1;
    while (acc_done_o !== 1'b1 && lat < 5) begin step; lat++; end
    // Pulses captured while they stand
    flg = {io_re_o, acc_unmapped_o};
    step;
  endtask
  // Loads use io 0x05 only, never reserved or stack high bytes
  task load(input logic [4:0] r, input logic [7:0] v);
    i_dsau_io_model.fill(v);
    acc(3'h5, 2'h0, 1'b0, 16'h0000, 6'h05, r);
  endtask
  task bitop(input logic s, input logic [2:0] bn, input logic [5:0] ad, input logic rf,
             input logic bv);
    {bit_set_i, bit_num_i, bit_io_i, bit_req_i} = {s, bn, ad, 1'b1};
    step;
    bit_req_i = 0;
    check(bit_done_o, 1);
    check(bit_refused_o, rf);
    if (!rf) check(bit_value_o, bv);
    step;
  endtask
  function automatic logic [7:0] alu_exp(int op, logic [7:0] x, logic [7:0] y);
    case (op)
      0: return x + y;
      1: return x - y;
      2: return x & y;
      3: return x | y;
      4: return x ^ y;
      default: return y;
    endcase
  endfunction
  // ******
  // Tests
  // ******
  initial begin
    void'($urandom(16));
    repeat (3) step;
    srst_i = 0;
    step;
    check(pc_o, 0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      a = $urandom;
      z = (i == 0) ? 16'h0060 : (i == 1) ? 16'h00df : 16'h0060 + 16'($urandom % 128);
      load(5'h05, a);
      check(flg, 2'h2);
      check(acc_addr_o, 16'h0025);
      check(acc_rdata_o, a);
      acc(3'h0, 2'h0, 1'b1, z, 6'h00, 5'h05);
      check(lat[15:0], 2);
      acc(3'h0, 2'h0, 1'b0, z, 6'h00, 5'h06);
      check(acc_rdata_o, a);
      acc(3'h0, 2'h0, 1'b0, 16'h00e0 + 16'($urandom % 16'hff20), 6'h00, 5'h06);
      check(flg, 2'h1);
      acc(3'h0, 2'h0, 1'b0, 16'h0006, 6'h00, 5'h07);
      check({lat[7:0], acc_rdata_o}, {8'h01, a});
    end
    $display("test map done");
    for (int p = 0; p < 3; p++) begin
      z = 16'h0061 + 16'($urandom % 64);
      a = 8'($urandom % 64);
      load(5'd26 + 5'(2 * p), z[7:0]);
      load(5'd27 + 5'(2 * p), z[15:8]);
      acc(3'h2, 2'(p), 1'b0, 16'h0000, 6'h00, 5'h08);
      check(acc_addr_o, z);
      if (p != 0) begin
        acc(3'h1, 2'(p), 1'b0, 16'h0000, a[5:0], 5'h08);
        check(acc_addr_o, z + a);
      end
      acc(3'h3, 2'(p), 1'b0, 16'h0000, 6'h00, 5'h08);
      check(acc_addr_o, z - 1);
      acc(3'h4, 2'(p), 1'b0, 16'h0000, 6'h00, 5'h08);
      check(acc_addr_o, z - 1);
      acc(3'h2, 2'(p), 1'b0, 16'h0000, 6'h00, 5'h08);
      check(acc_addr_o, z);
    end
    lpc_req_i = 1;
    step;
    lpc_req_i = 0;
    step;
    check({lpc_word_o, lpc_high_o}, {z[10:1], z[0]});
    {pc_step_i, pc_op_i} = {1'b1, 2'h1};
    step;
    pc_op_i = 2'h2;
    pc = z[9:0];
    check(pc_o, pc);
    for (int k = 0; k < 4; k++) begin
      pc_rel_i = (k == 0) ? 12'h800 : (k == 1) ? 12'h7ff : 12'($urandom);
      pc = pc + pc_rel_i[9:0] + 10'h001;
      step;
      check(pc_o, pc);
    end
    pc_step_i = 0;
    $display("test pointers and pc done");
    for (int op = 0; op < 6; op++) begin
      a = $urandom;
      b = $urandom;
      load(5'd10, a);
      load(5'd11, b);
      {alu_rd_i, alu_rr_i, alu_op_i, alu_req_i} = {5'd10, 5'd11, 3'(op), 1'b1};
      step;
      alu_req_i = 0;
      acc(3'h0, 2'h0, 1'b0, 16'h000a, 6'h00, 5'h0c);
      check(acc_rdata_o, alu_exp(op, a, b));
    end
    $display("test alu done");
    // Local core bytes written through io mode; only the stack low byte 0x3d read back
    a = $urandom;
    load(5'd13, a);
    load(5'd14, 8'h00);
    acc(3'h5, 2'h0, 1'b1, 16'h0000, 6'h3d, 5'd13);
    acc(3'h5, 2'h0, 1'b1, 16'h0000, 6'h3e, 5'd14);
    acc(3'h5, 2'h0, 1'b1, 16'h0000, 6'h3f, 5'd13);
    check(core_flags_o, a);
    check(stack_ptr_o, {8'h00, a});
    i_dsau_io_model.fill(~a);
    acc(3'h5, 2'h0, 1'b0, 16'h0000, 6'h3d, 5'd15);
    check(acc_rdata_o, a);
    $display("test core bytes done");
    i_dsau_io_model.fill(8'h81);
    bitop(1'b1, 3'h3, 6'h1f, 1'b0, 1'b0);
    check(i_dsau_io_model.last_wr, 8'h89);
    i_dsau_io_model.fill(8'h81);
    bitop(1'b0, 3'h7, 6'h07, 1'b0, 1'b1);
    check(i_dsau_io_model.last_wr, 8'h01);
    n = i_dsau_io_model.wr_cnt;
    bitop(1'b1, 3'h0, 6'h20, 1'b1, 1'b0);
    check(i_dsau_io_model.wr_cnt - n, 0);
    $display("test bit ops done");
    close_out;
  end
endmodule // tb_dsau_top
